// file: core/ufd_mem.sv
`timescale 1ns/10ps
module ufd_mem #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 4,
    parameter int unsigned AW = 2
) (
    // Clock
    input wire logic clk_in,
    // Write port
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [W-1:0] wdata_in,
    // Read port
    input wire logic [AW-1:0] raddr_in,
    output logic [W-1:0] rdata_out
);

    logic [W-1:0] mem_r [DEPTH];

    // Storage write
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_r[waddr_in] <= wdata_in;
        end
    end

    // Registered read with write-through so a fresh head is never stale
    always_ff @(posedge clk_in) begin
        if (we_in && (waddr_in == raddr_in)) begin
            rdata_out <= wdata_in;
        end else begin
            rdata_out <= mem_r[raddr_in];
        end
    end

endmodule

// file: core/ufd_pkg.sv
package ufd_pkg;

    // Queue geometry and character width
    localparam int unsigned UFD_FIFO_DEPTH = 4;
    localparam int unsigned UFD_CHAR_W = 8;

    // Request line asserts while at least this many entries are free
    localparam int unsigned UFD_RTS_MIN_FREE = 2;

    // Overrun offset leads the true overflow point by this many characters
    localparam int unsigned UFD_OVF_LEAD = 4;

    // Width of a DMA buffer offset
    localparam int unsigned UFD_OFS_W = 8;

    // DMA buffer indices
    localparam int unsigned UFD_BUF_A = 0;
    localparam int unsigned UFD_BUF_B = 1;
    localparam int unsigned UFD_NBUF = 2;

    // Interrupt event bit positions
    localparam int unsigned UFD_IRQ_TX_IDLE = 0;
    localparam int unsigned UFD_IRQ_TX_SPACE = 1;
    localparam int unsigned UFD_IRQ_RX_AVAIL = 2;
    localparam int unsigned UFD_IRQ_TX_DMA_A = 3;
    localparam int unsigned UFD_IRQ_TX_DMA_B = 4;
    localparam int unsigned UFD_IRQ_RX_DMA_A = 5;
    localparam int unsigned UFD_IRQ_RX_DMA_B = 6;
    localparam int unsigned UFD_IRQ_PAR_ERR = 7;
    localparam int unsigned UFD_IRQ_FRM_ERR = 8;
    localparam int unsigned UFD_IRQ_RX_OVF = 9;
    localparam int unsigned UFD_IRQ_N = 10;

    // Reset levels
    localparam logic UFD_LINE_IDLE = 1'b1;
    localparam logic UFD_RTS_N_RESET = 1'b1;

    // Static configuration bits
    typedef struct packed {
        logic flow_ctrl_enable;
        logic auto_rts_enable;
        logic soft_rts_level;
        logic irq_trigger_mode;
        logic top_irq_enable_set;
    } ufd_cfg_t;

    // Received character with its error flags
    typedef struct packed {
        logic perr;
        logic ferr;
        logic [UFD_CHAR_W-1:0] data;
    } ufd_rx_char_t;

    // Transmit sequencer states
    typedef enum logic [1:0] {
        UFD_TX_IDLE = 2'b01,
        UFD_TX_SHIFT = 2'b10
    } ufd_tx_state_t;

endpackage

// file: core/ufd_top.sv
`timescale 1ns/10ps
module ufd_top
    import ufd_pkg::*;
#(
    parameter int unsigned DEPTH = UFD_FIFO_DEPTH,
    parameter int unsigned OFS_W = UFD_OFS_W
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    // Configuration
    input wire ufd_cfg_t CFG_IN,
    input wire logic [UFD_IRQ_N-1:0] IRQ_MASK_IN,
    // Data port, software side
    input wire logic TX_WR_IN,
    input wire logic [UFD_CHAR_W-1:0] TX_DATA_IN,
    input wire logic RX_RD_IN,
    // Data port, DMA side
    input wire logic TX_DMA_WR_IN,
    input wire logic [UFD_CHAR_W-1:0] TX_DMA_DATA_IN,
    input wire logic RX_DMA_RD_IN,
    input wire logic RX_DMA_BUF_IN,
    input wire logic [OFS_W-1:0] RX_DMA_OFS_IN,
    input wire logic [UFD_NBUF-1:0] TX_BUF_ACTIVE_IN,
    input wire logic [UFD_NBUF-1:0] RX_BUF_ACTIVE_IN,
    input wire logic [UFD_NBUF-1:0] RX_BUF_LOAD_IN,
    input wire logic [UFD_NBUF-1:0] RX_DMA_RESET_IN,
    // Shifter side
    input wire logic TX_DONE_IN,
    input wire logic SER_TXD_IN,
    input wire logic RX_VALID_IN,
    input wire ufd_rx_char_t RX_CHAR_IN,
    // Handshake pins and transmit data line
    input wire logic CLEAR_TO_SEND_N_IN,
    output logic REQUEST_TO_SEND_N_OUT,
    output logic TXD_OUT,
    // Transmit shifter request
    output logic TX_START_OUT,
    output logic [UFD_CHAR_W-1:0] TX_CHAR_OUT,
    // Read data
    output ufd_rx_char_t RX_CHAR_OUT,
    // Status
    output logic TX_IDLE_FLAG_OUT,
    output logic TX_SPACE_FLAG_OUT,
    output logic RX_AVAIL_FLAG_OUT,
    output logic RX_OVERRUN_FLAG_OUT,
    output logic [UFD_NBUF-1:0] RX_DMA_ERR_OUT,
    output logic [OFS_W-1:0] RX_ERR_OFS_A_OUT,
    output logic [OFS_W-1:0] RX_ERR_OFS_B_OUT,
    // Interrupts
    output logic [UFD_IRQ_N-1:0] IRQ_EVENT_OUT,
    output logic SERIAL_CTRL_IRQ_OUT
);

    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_RTS = CW'(UFD_RTS_MIN_FREE);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    // Circular pointer advance, shared by both queues
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == PTR_LAST) ? '0 : p + AW'(1);
    endfunction

    ufd_tx_state_t tx_state_r;
    ufd_tx_state_t tx_state_nxt;
    logic [AW-1:0] tx_wp_r;
    logic [AW-1:0] tx_rp_r;
    logic [CW-1:0] tx_cnt_r;
    logic [AW-1:0] rx_wp_r;
    logic [AW-1:0] rx_rp_r;
    logic [CW-1:0] rx_cnt_r;
    logic [UFD_CHAR_W-1:0] tx_head;
    logic [UFD_CHAR_W-1:0] tx_wdata;
    ufd_rx_char_t rx_head;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic rx_overrun;
    logic tx_idle;
    logic tx_space;
    logic rx_avail;
    logic tx_idle_r;
    logic tx_space_r;
    logic rx_avail_r;
    logic [UFD_NBUF-1:0] tx_act_r;
    logic [UFD_NBUF-1:0] rx_act_r;
    logic [UFD_IRQ_N-1:0] irq_ev;
    logic [CW-1:0] rx_free;
    logic rts_n_nxt;
    logic err_r [UFD_NBUF];
    logic [OFS_W-1:0] ofs_r [UFD_NBUF];

    // Software write wins a collision with DMA; one character per cycle
    assign tx_wdata = TX_WR_IN ? TX_DATA_IN : TX_DMA_DATA_IN;
    assign tx_push = (TX_WR_IN | TX_DMA_WR_IN) && (tx_cnt_r != CNT_FULL);
    assign rx_push = RX_VALID_IN && (rx_cnt_r != CNT_FULL);
    assign rx_overrun = RX_VALID_IN && (rx_cnt_r == CNT_FULL);
    assign rx_pop = (RX_RD_IN | RX_DMA_RD_IN) && (rx_cnt_r != '0);

    // Start rule: queue holds data, shifter idle, clear asserted if required
    always_comb begin
        tx_pop = 1'b0;
        tx_state_nxt = tx_state_r;
        unique case (tx_state_r)
            UFD_TX_IDLE: begin
                if ((tx_cnt_r != '0) && (!CFG_IN.flow_ctrl_enable || !CLEAR_TO_SEND_N_IN)) begin
                    tx_pop = 1'b1;
                    tx_state_nxt = UFD_TX_SHIFT;
                end
            end
            UFD_TX_SHIFT: begin
                // Clear is not looked at here, so the character completes
                if (TX_DONE_IN) begin
                    tx_state_nxt = UFD_TX_IDLE;
                end
            end
            default: begin
                tx_state_nxt = UFD_TX_IDLE;
            end
        endcase
    end

    // Transmit sequencer state
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            tx_state_r <= UFD_TX_IDLE;
        end else begin
            tx_state_r <= tx_state_nxt;
        end
    end

    // Transmit queue pointers and fill count
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            tx_wp_r <= '0;
            tx_rp_r <= '0;
            tx_cnt_r <= '0;
        end else begin
            if (tx_push) begin
                tx_wp_r <= ptr_inc(tx_wp_r);
            end
            if (tx_pop) begin
                tx_rp_r <= ptr_inc(tx_rp_r);
            end
            tx_cnt_r <= tx_cnt_r + CW'(tx_push) - CW'(tx_pop);
        end
    end

    // Receive queue pointers and fill count
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            rx_wp_r <= '0;
            rx_rp_r <= '0;
            rx_cnt_r <= '0;
        end else begin
            if (rx_push) begin
                rx_wp_r <= ptr_inc(rx_wp_r);
            end
            if (rx_pop) begin
                rx_rp_r <= ptr_inc(rx_rp_r);
            end
            rx_cnt_r <= rx_cnt_r + CW'(rx_push) - CW'(rx_pop);
        end
    end

    // Storage; read address looks ahead so the head is valid every cycle
    ufd_mem #(.W(UFD_CHAR_W), .DEPTH(DEPTH), .AW(AW)) u_tx_mem (
        .clk_in(CLK_IN),
        .we_in(tx_push),
        .waddr_in(tx_wp_r),
        .wdata_in(tx_wdata),
        .raddr_in(tx_pop ? ptr_inc(tx_rp_r) : tx_rp_r),
        .rdata_out(tx_head)
    );

    ufd_mem #(.W($bits(ufd_rx_char_t)), .DEPTH(DEPTH), .AW(AW)) u_rx_mem (
        .clk_in(CLK_IN),
        .we_in(rx_push),
        .waddr_in(rx_wp_r),
        .wdata_in(RX_CHAR_IN),
        .raddr_in(rx_pop ? ptr_inc(rx_rp_r) : rx_rp_r),
        .rdata_out(rx_head)
    );

    // Shifter request and line drive; line rests high outside a character
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            TX_START_OUT <= 1'b0;
            TX_CHAR_OUT <= '0;
            TXD_OUT <= UFD_LINE_IDLE;
        end else begin
            TX_START_OUT <= tx_pop;
            if (tx_pop) begin
                TX_CHAR_OUT <= tx_head;
            end
            TXD_OUT <= (tx_state_r == UFD_TX_SHIFT) ? SER_TXD_IN : UFD_LINE_IDLE;
        end
    end

    // Read data register, loaded only on a pop
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            RX_CHAR_OUT <= '0;
        end else if (rx_pop) begin
            RX_CHAR_OUT <= rx_head;
        end
    end

    // Request line; threshold leaves one slot for a sender slow to stop
    assign rx_free = CNT_FULL - rx_cnt_r;
    always_comb begin
        if (!CFG_IN.flow_ctrl_enable) begin
            rts_n_nxt = UFD_RTS_N_RESET;
        end else if (CFG_IN.auto_rts_enable) begin
            rts_n_nxt = !(rx_free >= CNT_RTS);
        end else begin
            rts_n_nxt = !CFG_IN.soft_rts_level;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            REQUEST_TO_SEND_N_OUT <= UFD_RTS_N_RESET;
        end else begin
            REQUEST_TO_SEND_N_OUT <= rts_n_nxt;
        end
    end

    // Overrun flag; a new overrun beats a simultaneous read
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            RX_OVERRUN_FLAG_OUT <= 1'b0;
        end else if (rx_overrun) begin
            RX_OVERRUN_FLAG_OUT <= 1'b1;
        end else if (RX_RD_IN) begin
            RX_OVERRUN_FLAG_OUT <= 1'b0;
        end
    end

    // DMA error capture, one tracker per buffer
    for (genvar b = 0; b < UFD_NBUF; b++) begin : g_dma_err
        logic sel;
        logic char_err;
        logic ovf_hit;
        logic set_err;
        logic clr_err;
        assign sel = (RX_DMA_BUF_IN == b[0]);
        assign char_err = sel && rx_pop && RX_DMA_RD_IN && (rx_head.perr | rx_head.ferr);
        assign ovf_hit = sel && rx_overrun && RX_BUF_ACTIVE_IN[b];
        assign set_err = (char_err | ovf_hit) && !err_r[b];
        assign clr_err = RX_DMA_RESET_IN[b] | (RX_BUF_LOAD_IN[b] & !RX_BUF_ACTIVE_IN[b]);

        // Only the first error is kept; a set beats a clear in the same cycle
        always_ff @(posedge CLK_IN) begin
            if (SRST_IN) begin
                err_r[b] <= 1'b0;
                ofs_r[b] <= '0;
            end else if (set_err) begin
                err_r[b] <= 1'b1;
                if (char_err) begin
                    ofs_r[b] <= RX_DMA_OFS_IN;
                end else begin
                    ofs_r[b] <= RX_DMA_OFS_IN + OFS_W'(UFD_OVF_LEAD);
                end
            end else if (clr_err) begin
                err_r[b] <= 1'b0;
                ofs_r[b] <= '0;
            end
        end
        assign RX_DMA_ERR_OUT[b] = err_r[b];
    end

    assign RX_ERR_OFS_A_OUT = ofs_r[UFD_BUF_A];
    assign RX_ERR_OFS_B_OUT = ofs_r[UFD_BUF_B];

    // Live status
    assign tx_idle = (tx_cnt_r == '0) && (tx_state_r == UFD_TX_IDLE);
    assign tx_space = (tx_cnt_r != CNT_FULL);
    assign rx_avail = (rx_cnt_r != '0);

    // Previous values for edge detection
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            tx_idle_r <= 1'b1;
            tx_space_r <= 1'b1;
            rx_avail_r <= 1'b0;
            tx_act_r <= '0;
            rx_act_r <= '0;
        end else begin
            tx_idle_r <= tx_idle;
            tx_space_r <= tx_space;
            rx_avail_r <= rx_avail;
            tx_act_r <= TX_BUF_ACTIVE_IN;
            rx_act_r <= RX_BUF_ACTIVE_IN;
        end
    end

    // Event sources; for idle, space and receive, trigger mode 1 means level, 0 means rising edge
    always_comb begin
        irq_ev = '0;
        irq_ev[UFD_IRQ_TX_IDLE] = tx_idle && (CFG_IN.irq_trigger_mode || !tx_idle_r);
        irq_ev[UFD_IRQ_TX_SPACE] = tx_space && (CFG_IN.irq_trigger_mode || !tx_space_r);
        irq_ev[UFD_IRQ_RX_AVAIL] = rx_avail && (CFG_IN.irq_trigger_mode || !rx_avail_r);
        irq_ev[UFD_IRQ_TX_DMA_A] = tx_act_r[UFD_BUF_A] && !TX_BUF_ACTIVE_IN[UFD_BUF_A];
        irq_ev[UFD_IRQ_TX_DMA_B] = tx_act_r[UFD_BUF_B] && !TX_BUF_ACTIVE_IN[UFD_BUF_B];
        irq_ev[UFD_IRQ_RX_DMA_A] = rx_act_r[UFD_BUF_A] && !RX_BUF_ACTIVE_IN[UFD_BUF_A];
        irq_ev[UFD_IRQ_RX_DMA_B] = rx_act_r[UFD_BUF_B] && !RX_BUF_ACTIVE_IN[UFD_BUF_B];
        irq_ev[UFD_IRQ_PAR_ERR] = rx_push && RX_CHAR_IN.perr;
        irq_ev[UFD_IRQ_FRM_ERR] = rx_push && RX_CHAR_IN.ferr;
        irq_ev[UFD_IRQ_RX_OVF] = rx_overrun;
    end

    // Registered status, events and gated interrupt line
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            TX_IDLE_FLAG_OUT <= 1'b1;
            TX_SPACE_FLAG_OUT <= 1'b1;
            RX_AVAIL_FLAG_OUT <= 1'b0;
            IRQ_EVENT_OUT <= '0;
            SERIAL_CTRL_IRQ_OUT <= 1'b0;
        end else begin
            TX_IDLE_FLAG_OUT <= tx_idle;
            TX_SPACE_FLAG_OUT <= tx_space;
            RX_AVAIL_FLAG_OUT <= rx_avail;
            IRQ_EVENT_OUT <= irq_ev;
            SERIAL_CTRL_IRQ_OUT <= CFG_IN.top_irq_enable_set && |(irq_ev & IRQ_MASK_IN);
        end
    end

endmodule

// file: verification/tb_uart_fifo_flow_dma_irq.sv
`timescale 1ns/10ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, a); end end
module tb_uart_fifo_flow_dma_irq;
    import ufd_pkg::*;
    logic clk = 0;
    logic srst = 1;
    ufd_cfg_t cfg = '0;
    ufd_rx_char_t rxc = '0;
    ufd_rx_char_t rxo;
    ufd_rx_char_t er;
    logic [9:0] mask = '1;
    logic [9:0] evt;
    logic twr = 0, rrd = 0, tdw = 0, rdr = 0, dbuf = 0, rv = 0, stop = 1;
    logic done, ser, cts_n, rts_n, txd, start, ovf, tidle, tspace, ravail, irq;
    logic [7:0] td = 0, tdd = 0, ofs = 0, dly = 8, tch, oa, ob, e8;
    logic [1:0] tact = 0, ract = 0, load = 0, drst = 0, derr;
    int n_fail = 0, num_checks = 0, seed = 32'h2dca;
    logic [7:0] exp_tx[$];
    ufd_rx_char_t exp_rx[$];

    always #2.5 clk = ~clk;

    ufd_top i_dut (.CLK_IN(clk), .SRST_IN(srst), .CFG_IN(cfg), .IRQ_MASK_IN(mask),
        .TX_WR_IN(twr), .TX_DATA_IN(td), .RX_RD_IN(rrd), .TX_DMA_WR_IN(tdw),
        .TX_DMA_DATA_IN(tdd), .RX_DMA_RD_IN(rdr), .RX_DMA_BUF_IN(dbuf), .RX_DMA_OFS_IN(ofs),
        .TX_BUF_ACTIVE_IN(tact), .RX_BUF_ACTIVE_IN(ract), .RX_BUF_LOAD_IN(load),
        .RX_DMA_RESET_IN(drst), .TX_DONE_IN(done), .SER_TXD_IN(ser), .RX_VALID_IN(rv),
        .RX_CHAR_IN(rxc), .CLEAR_TO_SEND_N_IN(cts_n), .REQUEST_TO_SEND_N_OUT(rts_n),
        .TXD_OUT(txd), .TX_START_OUT(start), .TX_CHAR_OUT(tch), .RX_CHAR_OUT(rxo),
        .TX_IDLE_FLAG_OUT(tidle), .TX_SPACE_FLAG_OUT(tspace), .RX_AVAIL_FLAG_OUT(ravail),
        .RX_OVERRUN_FLAG_OUT(ovf), .RX_DMA_ERR_OUT(derr), .RX_ERR_OFS_A_OUT(oa),
        .RX_ERR_OFS_B_OUT(ob), .IRQ_EVENT_OUT(evt), .SERIAL_CTRL_IRQ_OUT(irq));
    ufd_far i_far (.clk_in(clk), .start_in(start), .dly_in(dly), .stop_in(stop),
        .done_out(done), .ser_out(ser), .cts_n_out(cts_n));

    // Results are matched against the oldest note when they appear
    always @(posedge clk) begin
        automatic logic rd = (rrd | rdr) && exp_rx.size() > 0;
        #1;
        if (start) begin
            e8 = exp_tx.pop_front();
            `CHK("tx char", e8, tch)
        end
        if (rd) begin
            er = exp_rx.pop_front();
            `CHK("rx char", er, rxo)
        end
    end

    task automatic cyc(int n = 1);
        repeat (n) @(negedge clk);
    endtask
    // Back-to-back writes keep the strobe high, so no same-step toggling
    task automatic wr_n(int n, logic dma);
        for (int i = 0; i < n; i++) begin
            twr = !dma;
            tdw = dma;
            td = 8'($random(seed));
            tdd = td;
            if (exp_tx.size() < 4)
                exp_tx.push_back(td);
            cyc();
        end
        twr = 0;
        tdw = 0;
    endtask
    task automatic rx_n(int n, logic [1:0] fl);
        for (int i = 0; i < n; i++) begin
            rv = 1;
            rxc = {fl, 8'($random(seed))};
            if (exp_rx.size() < 4)
                exp_rx.push_back(rxc);
            cyc();
        end
        rv = 0;
    endtask
    task automatic rd_n(int n, logic dma);
        rrd = !dma;
        rdr = dma;
        cyc(n);
        rrd = 0;
        rdr = 0;
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard at 20000 cycles, far beyond the expected couple of hundred cycles
    initial begin
        #(5 * 20000);
        n_fail++;
        close_out();
    end

    initial begin
        cyc(20);
        srst = 0;
        cyc();
        `CHK("idle line", 1'b1, txd)
        // Transmit: fill while clear is high, one overflow write
        cfg = 5'b10001;
        cyc(2);
        wr_n(3, 0);
        cyc();
        wr_n(2, 1);
        cyc(2);
        `CHK("tx space", 1'b0, tspace)
        `CHK("tx held", 4, exp_tx.size())
        stop = 0;
        dly = 20;
        for (int i = 0; i < 50 && !start; i++) cyc();
        stop = 1;
        tact = 2'b01;
        cyc(40);
        tact = 2'b00;
        `CHK("tx one", 3, exp_tx.size())
        dly = 3;
        cfg.flow_ctrl_enable = 0;
        for (int i = 0; i < 300 && !(exp_tx.size() == 0 && tidle); i++) cyc();
        `CHK("tx idle", 1'b1, tidle)
        `CHK("txd idle", 1'b1, txd)
        cfg.irq_trigger_mode = 1;
        cyc(2);
        `CHK("idle level", 1'b1, evt[UFD_IRQ_TX_IDLE])
        `CHK("irq line", 1'b1, irq)
        // Idle and space levels both masked, nothing else pending
        mask = 10'h3fc;
        cyc(2);
        `CHK("irq masked", 1'b0, irq)
        mask = '1;
        // Request line with flow off and with each manual level
        for (int m = 0; m < 3; m++) begin
            cfg = {m != 0, 1'b0, m == 1, 2'b01};
            cyc(2);
            `CHK("rts mode", m != 1, rts_n)
        end
        // Receive: auto request, overrun into buffer A
        cfg = 5'b11001;
        ract = 2'b01;
        ofs = 8'($random(seed));
        for (int i = 0; i < 5; i++) begin
            cyc(2);
            `CHK("rts auto", exp_rx.size() > 2, rts_n)
            rx_n(1, i == 2 ? 2'b10 : 2'b00);
        end
        cyc(2);
        `CHK("overrun", 1'b1, ovf)
        `CHK("dma err", 2'b01, derr)
        `CHK("ovf ofs", 8'(ofs + 8'h04), oa)
        drst = 2'b01;
        cyc();
        drst = 0;
        cyc();
        `CHK("err rst", 10'h000, {derr, oa})
        rd_n(2, 0);
        cyc();
        `CHK("ovf clr", 1'b0, ovf)
        rd_n(2, 1);
        cyc();
        `CHK("perr ofs", {2'b01, ofs}, {derr, oa})
        ract = 0;
        cyc();
        load = 2'b01;
        cyc();
        load = 0;
        cyc();
        `CHK("err load", 2'b00, derr)
        // Framing error event on an accepted character
        rx_n(1, 2'b01);
        e8 = {7'h00, evt[UFD_IRQ_FRM_ERR]};
        cyc();
        `CHK("frm evt", 1'b1, e8[0] | evt[UFD_IRQ_FRM_ERR])
        // Buffer B keeps its own first error
        dbuf = 1;
        rd_n(1, 1);
        cyc();
        `CHK("ofs b", {2'b10, ofs}, {derr, ob})
        // Prompt remote sends only while the request line is low
        for (int i = 0; i < 8 && !rts_n; i++) begin
            rx_n(1, 2'b00);
            cyc();
        end
        `CHK("no ovf", 1'b0, ovf)
        `CHK("prompt cnt", 3, exp_rx.size())
        rd_n(3, 0);
        cyc(4);
        close_out();
    end
endmodule

// file: verification/ufd_far.sv
`timescale 1ns/10ps
module ufd_far (
    // Clock and control from the bench
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic [7:0] dly_in,
    input wire logic stop_in,
    // Shifter answer and remote handshake
    output logic done_out,
    output logic ser_out,
    output logic cts_n_out
);
    int cnt = 0;
    // Shift time set by the bench, so slow and prompt answers both occur
    always_ff @(posedge clk_in) begin
        done_out <= start_in ? 1'b0 : (cnt == 1);
        cnt <= start_in ? int'(dly_in) : (cnt > 0 ? cnt - 1 : 0);
        ser_out <= (cnt > 0) ? ~ser_out : 1'b1;
        cts_n_out <= stop_in;
    end
endmodule

// file: verification/ufd_top_chk.sv
`timescale 1ns/10ps
module ufd_top_chk
    import ufd_pkg::*;
#(
    parameter int unsigned DEPTH = UFD_FIFO_DEPTH,
    parameter int unsigned OFS_W = UFD_OFS_W
) (
    // Clock, reset and setup
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire ufd_cfg_t CFG_IN,
    input wire logic [UFD_IRQ_N-1:0] IRQ_MASK_IN,
    // Stimulus
    input wire logic RX_VALID_IN,
    input wire logic TX_DONE_IN,
    input wire logic CLEAR_TO_SEND_N_IN,
    input wire logic RX_DMA_BUF_IN,
    input wire logic [UFD_NBUF-1:0] TX_BUF_ACTIVE_IN,
    input wire logic [UFD_NBUF-1:0] RX_BUF_ACTIVE_IN,
    // Outputs watched
    input wire logic REQUEST_TO_SEND_N_OUT,
    input wire logic TX_START_OUT,
    input wire logic RX_AVAIL_FLAG_OUT,
    input wire logic RX_OVERRUN_FLAG_OUT,
    input wire logic [UFD_NBUF-1:0] RX_DMA_ERR_OUT,
    input wire logic [UFD_IRQ_N-1:0] IRQ_EVENT_OUT,
    input wire logic SERIAL_CTRL_IRQ_OUT
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SRST_IN);

    // Shifter busy from a start until its done pulse; done wins, it ends this character
    logic busy_r;
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            busy_r <= 1'b0;
        end else if (TX_DONE_IN) begin
            busy_r <= 1'b0;
        end else if (TX_START_OUT) begin
            busy_r <= 1'b1;
        end
    end

    // Two steady cycles, since the request line is registered
    sequence s_flow_off;
        !CFG_IN.flow_ctrl_enable ##1 !CFG_IN.flow_ctrl_enable;
    endsequence
    sequence s_manual;
        (CFG_IN.flow_ctrl_enable && !CFG_IN.auto_rts_enable)[*2];
    endsequence
    sequence s_ovf_rise;
        $rose(RX_OVERRUN_FLAG_OUT);
    endsequence

    property p_rts_off;
        s_flow_off |-> REQUEST_TO_SEND_N_OUT;
    endproperty
    property p_rts_soft;
        s_manual ##0 $stable(CFG_IN.soft_rts_level) |-> REQUEST_TO_SEND_N_OUT
            == !CFG_IN.soft_rts_level;
    endproperty
    property p_start_cts;
        TX_START_OUT |-> $past(!CLEAR_TO_SEND_N_IN || !CFG_IN.flow_ctrl_enable);
    endproperty
    property p_one_flight;
        TX_START_OUT |-> !busy_r;
    endproperty
    property p_rx_avail;
        RX_VALID_IN |-> ##[1:2] RX_AVAIL_FLAG_OUT;
    endproperty
    property p_ovf_evt;
        s_ovf_rise |-> ##[0:1] IRQ_EVENT_OUT[UFD_IRQ_RX_OVF];
    endproperty
    property p_ovf_dma;
        s_ovf_rise ##0 $past(RX_BUF_ACTIVE_IN[0] && !RX_DMA_BUF_IN) |-> RX_DMA_ERR_OUT[0];
    endproperty
    property p_tx_done;
        $fell(TX_BUF_ACTIVE_IN[0]) |=> IRQ_EVENT_OUT[UFD_IRQ_TX_DMA_A];
    endproperty
    property p_rx_done;
        $fell(RX_BUF_ACTIVE_IN[0]) |=> IRQ_EVENT_OUT[UFD_IRQ_RX_DMA_A];
    endproperty
    property p_irq_gate;
        SERIAL_CTRL_IRQ_OUT == ($past(CFG_IN.top_irq_enable_set)
            && |(IRQ_EVENT_OUT & $past(IRQ_MASK_IN)));
    endproperty

    a_rts_off: assert property (p_rts_off) else $error("request low with flow off");
    a_rts_soft: assert property (p_rts_soft) else $error("request ignores soft level");
    a_start_cts: assert property (p_start_cts) else $error("start while clear high");
    a_one_flight: assert property (p_one_flight) else $error("start during shift");
    a_rx_avail: assert property (p_rx_avail) else $error("receive flag missing");
    a_ovf_evt: assert property (p_ovf_evt) else $error("overrun event missing");
    a_ovf_dma: assert property (p_ovf_dma) else $error("overrun dma error missing");
    a_tx_done: assert property (p_tx_done) else $error("tx buffer done missing");
    a_rx_done: assert property (p_rx_done) else $error("rx buffer done missing");
    a_irq_gate: assert property (p_irq_gate) else $error("irq line mismatch");
endmodule

bind ufd_top ufd_top_chk #(.DEPTH(DEPTH), .OFS_W(OFS_W)) i_chk (
    .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .CFG_IN(CFG_IN), .IRQ_MASK_IN(IRQ_MASK_IN),
    .RX_VALID_IN(RX_VALID_IN), .TX_DONE_IN(TX_DONE_IN),
    .CLEAR_TO_SEND_N_IN(CLEAR_TO_SEND_N_IN), .RX_DMA_BUF_IN(RX_DMA_BUF_IN),
    .TX_BUF_ACTIVE_IN(TX_BUF_ACTIVE_IN), .RX_BUF_ACTIVE_IN(RX_BUF_ACTIVE_IN),
    .REQUEST_TO_SEND_N_OUT(REQUEST_TO_SEND_N_OUT), .TX_START_OUT(TX_START_OUT),
    .RX_AVAIL_FLAG_OUT(RX_AVAIL_FLAG_OUT), .RX_OVERRUN_FLAG_OUT(RX_OVERRUN_FLAG_OUT),
    .RX_DMA_ERR_OUT(RX_DMA_ERR_OUT), .IRQ_EVENT_OUT(IRQ_EVENT_OUT),
    .SERIAL_CTRL_IRQ_OUT(SERIAL_CTRL_IRQ_OUT)
);
